/* File: src/dtfls_sequencer.sv */
// Purpose: controller that trims, stores and fast-reloads an oscillator calibration
// Assumes: oscillator pins and store are synchronous to clk except lock and fault status
// Notes: software reaches control and status over apb
// Functional notes
// RULE_01: range select is the preset whose nominal frequency is nearest the target, within 0 to 7.
// RULE_02: the trim search ends on a midpoint crossing and is guarded against never ending.
// RULE_03: settings are chosen so the locked tap sits near midrange, away from 0 and 511.
// RULE_04: before locking in fast lock the system clock goes to the reference and waits 10 cycles.
// RULE_05: after the first trim the tap, coarse trim and range are saved with a calibration flag.
// RULE_06: at reset with the flag set the saved values are loaded instead of searching.
// RULE_07: after reload a delay elapses, then lock status is checked before trusting the clock.
// RULE_08: the search ends early when the tap lies within the threshold (50) of 256.
// RULE_09: the oscillator loop tracks its reference once locked; drift follows the reference.
// RULE_10: range is 3 bits, coarse trim 3 bits, tap 0 to 511, modulation disabled.
// RULE_11: the target is one of 3.2 MHz (default), 1 MHz or 8 MHz.
// RULE_12: loop reference is internal (default) or crystal.
// RULE_13: the crystal is the preferred reference when drift is large and accuracy matters.
// RULE_14: trim steps down for a tap below 256, up otherwise; the closest setting is reloaded.
// RULE_15: after tap 256 and fault clear, wait 24 reference periods, then poll for lock without fault.
// RULE_16: the calibration flag is written only after all saved values are written.
// RULE_17: iterations are bounded and a trim limit without crossing reports failure.
`timescale 1ns/100ps
module dtfls_sequencer #(
    parameter int REF_HZ = 32768,
    parameter int DELAY_CYC = int'(longint'(dtfls_pkg::LOCK_WAIT_REF) * dtfls_pkg::CLK_MHZ * 1000000 / REF_HZ),
    parameter logic [8:0] TAP_DELTA = dtfls_pkg::TAP_DELTA_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [dtfls_pkg::RSEL_W-1:0] osc_range_select,
    output logic [dtfls_pkg::TRIM_W-1:0] osc_coarse_trim,
    output logic [dtfls_pkg::TAP_W-1:0] osc_tap_out,
    output logic osc_tap_load,
    output logic modulation_disable,
    output logic loop_enable,
    output logic ref_select_crystal,
    output logic sysclk_on_ref,
    output logic fault_clear,
    input wire logic [dtfls_pkg::TAP_W-1:0] osc_tap_in,
    input wire logic loop_unlock_status,
    input wire logic osc_fault_flag,
    output logic nv_write,
    output logic [1:0] nv_addr,
    output logic [15:0] nv_wdata,
    input wire logic [15:0] nv_flag_rd,
    input wire logic [15:0] nv_tap_rd,
    input wire logic [15:0] nv_trim_rsel_rd
);
    import dtfls_pkg::*;

    typedef enum {ST_BOOT, ST_IDLE, ST_SETUP, ST_WAIT, ST_POLL, ST_STEP, ST_RELOAD,
                  ST_NV_TAP, ST_NV_TR, ST_NV_FLAG, ST_REFSW, ST_FWAIT, ST_FPOLL, ST_DONE} dtfls_state_e;
    localparam int CW = $clog2(DELAY_CYC + REF_SWITCH_CYC + 2);
    localparam logic [CW-1:0] WAIT_CYC = CW'(DELAY_CYC);
    localparam logic [CW-1:0] SW_CYC = CW'(REF_SWITCH_CYC);

    dtfls_state_e state;
    logic [CW-1:0] cnt;
    logic [4:0] iter;
    logic [1:0] unl_s1, flt_s1;
    logic unl_s2;
    logic lock_ok;
    logic [TAP_W-1:0] delta;
    logic [TAP_W-1:0] best_delta;
    logic [TAP_W-1:0] best_tap;
    logic [TRIM_W-1:0] best_trim;
    logic [RSEL_W-1:0] best_rsel;
    logic saw_low, saw_high;
    logic [1:0] target;
    logic xtal;
    logic start_req, recal_req;
    logic [NUM_EV-1:0] ev_stat, ev_mask, ev_set;
    logic wr_en, rd_en;
    logic [RSEL_W-1:0] rsel_pick;
    logic [TAP_W-1:0] trim_tap_delta_threshold;

    // ----------------------------------------
    // status synchronisers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        unl_s1 <= {unl_s1[0], loop_unlock_status};
        flt_s1 <= {flt_s1[0], osc_fault_flag};
        unl_s2 <= unl_s1[1];
    end
    assign lock_ok = !unl_s1[1] && !flt_s1[1]; // RULE_15

    assign delta = (osc_tap_in >= TAP_MID) ? osc_tap_in - TAP_MID : TAP_MID - osc_tap_in;

    always_comb
    begin
        unique case (target)
            TGT_1M: rsel_pick = RSEL_FOR_1M; // RULE_01
            TGT_8M: rsel_pick = RSEL_FOR_8M; // RULE_01
            default: rsel_pick = RSEL_FOR_3M2; // RULE_01 RULE_11
        endcase
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            target <= TGT_3M2; // RULE_11
            xtal <= 1'b0; // RULE_12
            ev_mask <= '0;
            trim_tap_delta_threshold <= TAP_DELTA; // RULE_08
            start_req <= 1'b0;
            recal_req <= 1'b0;
        end
        else
        begin
            start_req <= 1'b0;
            recal_req <= 1'b0;
            if (wr_en && paddr == OFF_CTRL)
            begin
                start_req <= pwdata[CTRL_START_BIT];
                recal_req <= pwdata[CTRL_RECAL_BIT];
                xtal <= pwdata[CTRL_XTAL_BIT]; // RULE_12 RULE_13
                target <= (pwdata[CTRL_TGT_LSB+:2] > TGT_8M) ? TGT_3M2 : pwdata[CTRL_TGT_LSB+:2];
            end
            if (wr_en && paddr == OFF_IRQ_MASK)
                ev_mask <= pwdata[NUM_EV-1:0];
            if (wr_en && paddr == OFF_CONFIG)
                trim_tap_delta_threshold <= pwdata[TAP_W-1:0]; // RULE_08
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > OFF_CONFIG;
            if (rd_en)
            begin
                unique case (paddr)
                    OFF_CTRL: prdata <= {26'h0, target, 1'b0, xtal, 2'h0};
                    OFF_STATUS: prdata <= {23'h0, iter, lock_ok, 3'(state == ST_DONE)};
                    OFF_IRQ_STAT: prdata <= {28'h0, ev_stat};
                    OFF_IRQ_MASK: prdata <= {28'h0, ev_mask};
                    OFF_RESULT: prdata <= {9'h0, best_rsel, 1'b0, best_trim, 7'h0, best_tap};
                    OFF_CONFIG: prdata <= {23'h0, trim_tap_delta_threshold};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
            ev_stat <= '0;
        else if (wr_en && paddr == OFF_IRQ_STAT)
            ev_stat <= (ev_stat & ~pwdata[NUM_EV-1:0]) | ev_set;
        else
            ev_stat <= ev_stat | ev_set;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(ev_stat & ev_mask);
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= ST_BOOT;
            cnt <= '0;
            iter <= '0;
            ev_set <= '0;
            osc_range_select <= RSEL_FOR_3M2;
            osc_coarse_trim <= TRIM_DEF;
            osc_tap_out <= '0;
            osc_tap_load <= 1'b0;
            modulation_disable <= 1'b1; // RULE_10
            loop_enable <= 1'b0;
            ref_select_crystal <= 1'b0;
            sysclk_on_ref <= 1'b0;
            fault_clear <= 1'b0;
            nv_write <= 1'b0;
            nv_addr <= NV_TAP;
            nv_wdata <= '0;
            best_delta <= TAP_MAX;
            best_tap <= TAP_MID;
            best_trim <= TRIM_DEF;
            best_rsel <= RSEL_FOR_3M2;
            saw_low <= 1'b0;
            saw_high <= 1'b0;
        end
        else
        begin
            ev_set <= '0;
            osc_tap_load <= 1'b0;
            fault_clear <= 1'b0;
            nv_write <= 1'b0;
            if (cnt != '0)
                cnt <= cnt - 1'b1;
            unique case (state)
                ST_BOOT:
                    if (nv_flag_rd == NV_FLAG_VAL)
                    begin
                        osc_tap_out <= nv_tap_rd[TAP_W-1:0]; // RULE_06
                        osc_coarse_trim <= nv_trim_rsel_rd[TRIM_W-1:0]; // RULE_06
                        osc_range_select <= nv_trim_rsel_rd[8+:RSEL_W]; // RULE_06
                        osc_tap_load <= 1'b1;
                        ref_select_crystal <= xtal;
                        loop_enable <= 1'b1;
                        sysclk_on_ref <= 1'b1; // RULE_04
                        cnt <= SW_CYC;
                        state <= ST_REFSW;
                    end
                    else
                        state <= ST_IDLE;
                ST_IDLE, ST_DONE:
                    if (recal_req || (start_req && state == ST_IDLE))
                    begin
                        osc_range_select <= rsel_pick; // RULE_01 RULE_03
                        osc_coarse_trim <= TRIM_DEF;
                        ref_select_crystal <= xtal; // RULE_12
                        loop_enable <= 1'b1;
                        iter <= '0;
                        best_delta <= TAP_MAX;
                        saw_low <= 1'b0;
                        saw_high <= 1'b0;
                        state <= ST_SETUP;
                    end
                    else if (state == ST_DONE && unl_s1[1] && !unl_s2)
                        ev_set[EV_UNLOCK] <= 1'b1; // RULE_09
                ST_SETUP:
                begin
                    osc_tap_out <= TAP_MID; // RULE_15
                    osc_tap_load <= 1'b1;
                    fault_clear <= 1'b1; // RULE_15
                    cnt <= WAIT_CYC; // RULE_15
                    state <= ST_WAIT;
                end
                ST_WAIT:
                    if (cnt == '0)
                        state <= ST_POLL;
                ST_POLL:
                    if (lock_ok) // RULE_15
                    begin
                        if (delta < best_delta) // RULE_14
                        begin
                            best_delta <= delta;
                            best_tap <= osc_tap_in;
                            best_trim <= osc_coarse_trim;
                            best_rsel <= osc_range_select;
                        end
                        state <= ST_STEP;
                    end
                ST_STEP:
                begin
                    iter <= iter + 1'b1;
                    if (osc_tap_in < TAP_MID)
                        saw_low <= 1'b1;
                    else
                        saw_high <= 1'b1;
                    if (best_delta < trim_tap_delta_threshold) // RULE_08
                        state <= ST_RELOAD;
                    else if ((osc_tap_in < TAP_MID && saw_high) || (osc_tap_in >= TAP_MID && saw_low))
                        state <= ST_RELOAD; // RULE_02
                    else if (iter == 5'(MAX_ITER - 1) || (osc_tap_in < TAP_MID && osc_coarse_trim == '0)
                             || (osc_tap_in >= TAP_MID && osc_coarse_trim == TRIM_LIM))
                    begin
                        ev_set[EV_FAIL] <= 1'b1; // RULE_17 RULE_02
                        state <= ST_RELOAD;
                    end
                    else
                    begin
                        if (osc_tap_in < TAP_MID)
                            osc_coarse_trim <= osc_coarse_trim - 1'b1; // RULE_14
                        else
                            osc_coarse_trim <= osc_coarse_trim + 1'b1; // RULE_14
                        state <= ST_SETUP;
                    end
                end
                ST_RELOAD:
                begin
                    osc_tap_out <= best_tap; // RULE_14 RULE_03
                    osc_coarse_trim <= best_trim;
                    osc_range_select <= best_rsel;
                    osc_tap_load <= 1'b1;
                    nv_write <= 1'b1;
                    nv_addr <= NV_TAP; // RULE_05
                    nv_wdata <= {7'h0, best_tap};
                    state <= ST_NV_TAP;
                end
                ST_NV_TAP:
                begin
                    nv_write <= 1'b1;
                    nv_addr <= NV_TRIM_RSEL; // RULE_05
                    nv_wdata <= {5'h0, best_rsel, 5'h0, best_trim};
                    state <= ST_NV_TR;
                end
                ST_NV_TR:
                begin
                    nv_write <= 1'b1;
                    nv_addr <= NV_FLAG; // RULE_16
                    nv_wdata <= NV_FLAG_VAL;
                    state <= ST_NV_FLAG;
                end
                ST_NV_FLAG:
                begin
                    ev_set[EV_DONE] <= 1'b1;
                    state <= ST_DONE;
                end
                ST_REFSW:
                    if (cnt == '0)
                    begin
                        cnt <= WAIT_CYC; // RULE_07
                        state <= ST_FWAIT;
                    end
                ST_FWAIT:
                    if (cnt == '0)
                        state <= ST_FPOLL;
                ST_FPOLL:
                    if (lock_ok) // RULE_07
                    begin
                        sysclk_on_ref <= 1'b0;
                        ev_set[EV_FAST] <= 1'b1;
                        state <= ST_DONE;
                    end
            endcase
        end
    end
endmodule : dtfls_sequencer

/* File: src/dtfls_pkg.sv */
// Purpose: constants for the oscillator trim and fast lock sequencer
// Assumes: 200 MHz system clock, APB register access
// Notes: offsets are byte addresses of one-word registers
package dtfls_pkg;
    // ----------------------------------------
    // apb register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_CONFIG = 8'h14;
    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_RECAL_BIT = 1;
    localparam int CTRL_XTAL_BIT = 2;
    localparam int CTRL_TGT_LSB = 4;
    // ----------------------------------------
    // status and interrupt fields
    // ----------------------------------------
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_FAST = 2;
    localparam int EV_UNLOCK = 3;
    localparam int NUM_EV = 4;
    // ----------------------------------------
    // oscillator fields
    // ----------------------------------------
    localparam int TAP_W = 9;
    localparam int TRIM_W = 3;
    localparam int RSEL_W = 3;
    localparam logic [TAP_W-1:0] TAP_MID = 9'h100;
    localparam logic [TAP_W-1:0] TAP_MAX = 9'h1FF;
    localparam logic [TAP_W-1:0] TAP_DELTA_DEF = 9'h032;
    localparam logic [TRIM_W-1:0] TRIM_DEF = 3'h3;
    localparam logic [TRIM_W-1:0] TRIM_LIM = 3'h7;
    localparam logic [RSEL_W-1:0] RSEL_LIM = 3'h7;
    // ----------------------------------------
    // targets: 0 = 3.2 MHz (default), 1 = 1 MHz, 2 = 8 MHz
    // ----------------------------------------
    localparam logic [1:0] TGT_3M2 = 2'h0;
    localparam logic [1:0] TGT_1M = 2'h1;
    localparam logic [1:0] TGT_8M = 2'h2;
    localparam logic [RSEL_W-1:0] RSEL_FOR_3M2 = 3'h2;
    localparam logic [RSEL_W-1:0] RSEL_FOR_1M = 3'h0;
    localparam logic [RSEL_W-1:0] RSEL_FOR_8M = 3'h3;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int REF_SWITCH_CYC = 10;
    localparam int LOCK_WAIT_REF = 24;
    localparam int MAX_ITER = 16;
    // ----------------------------------------
    // nonvolatile store addresses
    // ----------------------------------------
    localparam logic [1:0] NV_TAP = 2'h0;
    localparam logic [1:0] NV_TRIM_RSEL = 2'h1;
    localparam logic [1:0] NV_FLAG = 2'h2;
    localparam logic [15:0] NV_FLAG_VAL = 16'hA55A;
endpackage : dtfls_pkg

/* File: dv/dtfls_osc_model.sv */
// Purpose: behavioural oscillator, locked loop and nonvolatile store
// Assumes: tap settles eight cycles after each load
// Notes: base is the locked tap at coarse trim 0
`timescale 1ns/100ps
module dtfls_osc_model (
    input wire logic clk,
    input wire logic [2:0] osc_coarse_trim,
    input wire logic [8:0] osc_tap_out,
    input wire logic osc_tap_load,
    input wire logic loop_enable,
    input wire logic nv_write,
    input wire logic [1:0] nv_addr,
    input wire logic [15:0] nv_wdata,
    input wire logic [9:0] base,
    output logic [8:0] osc_tap_in,
    output logic loop_unlock_status,
    output logic osc_fault_flag,
    output logic [15:0] nv_flag_rd,
    output logic [15:0] nv_tap_rd,
    output logic [15:0] nv_trim_rsel_rd
);
    logic [3:0] cnt = 4'h0;
    logic [8:0] held = 9'h000;
    logic [15:0] nv_mem [0:2] = '{16'hFFFF, 16'hFFFF, 16'hFFFF};
    int v;
    // ----
    // settling after a tap load
    // ----
    always_ff @(posedge clk)
    begin
        if (osc_tap_load)
            cnt <= 4'h8;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
        if (osc_tap_load)
            held <= osc_tap_out;
    end
    always_ff @(posedge clk)
    begin
        if (nv_write && nv_addr != 2'h3)
            nv_mem[nv_addr] <= nv_wdata;
    end
    assign v = int'(base) - 48 * int'(osc_coarse_trim);
    assign osc_tap_in = (cnt != 4'h0) ? held : (v < 0) ? 9'h000 : (v > 511) ? 9'h1FF : 9'(v);
    assign loop_unlock_status = !loop_enable || cnt != 4'h0;
    assign osc_fault_flag = cnt > 4'h5;
    assign nv_tap_rd = nv_mem[0];
    assign nv_trim_rsel_rd = nv_mem[1];
    assign nv_flag_rd = nv_mem[2];
endmodule : dtfls_osc_model

/* File: dv/dtfls_sequencer_sva.sv */
// Purpose: port checker for the trim and fast lock sequencer
// Assumes: one clock, sync reset
// Notes: bound to the sequencer below
`timescale 1ns/100ps
module dtfls_sequencer_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [dtfls_pkg::TRIM_W-1:0] osc_coarse_trim,
    input wire logic [dtfls_pkg::TAP_W-1:0] osc_tap_out,
    input wire logic modulation_disable,
    input wire logic sysclk_on_ref,
    input wire logic fault_clear,
    input wire logic nv_write,
    input wire logic [1:0] nv_addr,
    input wire logic [15:0] nv_wdata
);
    import dtfls_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_trim_wr;
        nv_write && nv_addr == NV_TRIM_RSEL;
    endsequence
    sequence s_flag_wr;
        nv_write && nv_addr == NV_FLAG && nv_wdata == NV_FLAG_VAL;
    endsequence
    AST_MOD_DIS: assert property (modulation_disable)
        else $error("modulation left enabled");
    AST_NV_ORDER: assert property (nv_write && nv_addr == NV_TAP |=> s_trim_wr ##1 s_flag_wr)
        else $error("store write order broken");
    AST_FLAG_LAST: assert property (nv_write && nv_addr == NV_FLAG |-> $past(nv_write) && $past(nv_addr) == NV_TRIM_RSEL)
        else $error("flag written early");
    AST_TAP_MID: assert property (fault_clear |-> osc_tap_out == TAP_MID)
        else $error("tap not midrange at fault clear");
    AST_LOCK_WAIT: assert property (fault_clear |=> (!fault_clear && $stable(osc_coarse_trim))[*8])
        else $error("trim stepped before lock wait");
    AST_REF_WAIT: assert property ($rose(sysclk_on_ref) |-> sysclk_on_ref[*8] ##1 sysclk_on_ref[*2])
        else $error("reference clock hold too short");
    AST_PREADY: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_SLVERR: assert property (psel && penable && pready && paddr > 8'h14 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
endmodule : dtfls_sequencer_sva
bind dtfls_sequencer dtfls_sequencer_sva i_sva (.clk, .reset, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .osc_coarse_trim, .osc_tap_out, .modulation_disable, .sysclk_on_ref, .fault_clear,
    .nv_write, .nv_addr, .nv_wdata);

/* File: dv/tb_dtfls_sequencer.sv */
// Purpose: self-checking bench for the trim and fast lock sequencer
// Assumes: 200 MHz clock, shortened lock wait
// Notes: reads are checked from a queue by a monitor
`timescale 1ns/100ps
module tb_dtfls_sequencer;
    import dtfls_pkg::*;
    localparam int DLY = 40;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, e, m, r;
    logic pready, pslverr, irq, osc_tap_load, modulation_disable, loop_enable, nv_write;
    logic ref_select_crystal, sysclk_on_ref, fault_clear, loop_unlock_status, osc_fault_flag;
    logic [2:0] osc_range_select, osc_coarse_trim, rs;
    logic [8:0] osc_tap_out, osc_tap_in;
    logic [1:0] nv_addr;
    logic [15:0] nv_wdata, nv_flag_rd, nv_tap_rd, nv_trim_rsel_rd;
    logic [9:0] base = 10'h19E;
    logic [31:0] exp_q[$], msk_q[$];
    int miscompares = 0;
    int num_checks = 0;
    int nclr = 0;
    int n;
    always #2.5 clk = ~clk;
    dtfls_sequencer #(.DELAY_CYC(DLY)) i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .osc_range_select, .osc_coarse_trim, .osc_tap_out, .osc_tap_load,
        .modulation_disable, .loop_enable, .ref_select_crystal, .sysclk_on_ref, .fault_clear, .osc_tap_in,
        .loop_unlock_status, .osc_fault_flag, .nv_write, .nv_addr, .nv_wdata, .nv_flag_rd, .nv_tap_rd,
        .nv_trim_rsel_rd);
    dtfls_osc_model i_osc (.clk, .osc_coarse_trim, .osc_tap_out, .osc_tap_load, .loop_enable, .nv_write,
        .nv_addr, .nv_wdata, .base, .osc_tap_in, .loop_unlock_status, .osc_fault_flag, .nv_flag_rd,
        .nv_tap_rd, .nv_trim_rsel_rd);
    // ----
    // shared tasks
    // ----
    task automatic close_out;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x)
        begin
            $display("unexpected %s expected %h seen %h", nm, x, s);
            miscompares++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] k);
        int i;
        @(posedge clk);
        if (!w)
        begin
            exp_q.push_back(d & k);
            msk_q.push_back(k);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            miscompares++;
            close_out();
        end
    endtask : apb
    task automatic run(input logic [31:0] c);
        apb(1'b1, OFF_CTRL, c, 32'h0);
        n = 0;
        while (irq !== 1'b1 && n < 4000)
        begin
            @(posedge clk);
            n++;
        end
        if (irq !== 1'b1)
        begin
            miscompares++;
            close_out();
        end
    endtask : run
    task automatic clr;
        apb(1'b1, OFF_IRQ_STAT, 32'hF, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq clear", irq, 1'b0);
    endtask : clr
    // ----
    // read monitor
    // ----
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1)
            chk("slave error", pslverr, paddr > OFF_CONFIG);
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("read data", prdata & m, e);
        end
        if (fault_clear === 1'b1)
            nclr++;
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        void'($urandom(32'h8089));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("reset outs", {modulation_disable, osc_range_select, osc_coarse_trim, irq, ref_select_crystal},
            {1'b1, 3'h2, 3'h3, 1'b0, 1'b0});
        apb(1'b0, 8'h18, 32'h0, 32'hFFFFFFFF);
        r = $urandom();
        apb(1'b1, OFF_IRQ_MASK, r, 32'h0);
        apb(1'b0, OFF_IRQ_MASK, r, 32'hF);
        apb(1'b1, OFF_IRQ_MASK, 32'h3, 32'h0);
        for (int t = 1; t < 4; t++)
        begin
            rs = (t == 1) ? RSEL_FOR_1M : (t == 2) ? RSEL_FOR_8M : RSEL_FOR_3M2;
            run(32'h3 | (32'(t) << CTRL_TGT_LSB) | (32'(t == 2) << CTRL_XTAL_BIT));
            chk("range", osc_range_select, rs);
            chk("crystal", ref_select_crystal, t == 2);
            apb(1'b0, OFF_RESULT, 32'h3010E | (32'(rs) << 20), 32'h7FF1FF);
            apb(1'b0, OFF_STATUS, 32'h1, 32'h1);
            clr();
        end
        base <= 10'h3FF;
        run(32'h3);
        apb(1'b0, OFF_IRQ_STAT, 32'h2, 32'h2);
        apb(1'b1, OFF_IRQ_MASK, 32'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", irq, 1'b0);
        apb(1'b1, OFF_IRQ_MASK, 32'h2, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq unmasked", irq, 1'b1);
        clr();
        apb(1'b1, OFF_IRQ_MASK, 32'h3, 32'h0);
        base <= 10'h1B2;
        apb(1'b1, OFF_CONFIG, 32'hA, 32'h0);
        apb(1'b0, OFF_CONFIG, 32'hA, 32'h1FF);
        run(32'h3);
        apb(1'b0, OFF_RESULT, 32'h2400F2, 32'h7FF1FF);
        chk("store values", {nv_tap_rd, nv_trim_rsel_rd}, {16'h00F2, 16'h0204});
        chk("store flag", nv_flag_rd, NV_FLAG_VAL);
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        nclr = 0;
        n = 0;
        while (sysclk_on_ref !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (sysclk_on_ref === 1'b1 && n < 1000)
        begin
            @(posedge clk);
            n++;
        end
        chk("ref hold", n >= DLY + REF_SWITCH_CYC && n < 1000, 1'b1);
        chk("reload", {osc_range_select, osc_coarse_trim, osc_tap_out}, 32'h28F2);
        repeat (20) @(posedge clk);
        apb(1'b0, OFF_IRQ_STAT, 32'h4, 32'h4);
        chk("no search", nclr, 32'h0);
        close_out();
    end
endmodule : tb_dtfls_sequencer
